// [rps_core_if.sv]
/*
  Bundle between the register top, the pointer stepper and the lane swapper.
  Assumes all three run on the same clock; stepper and swapper outputs here are combinational.
*/
`timescale 1ns/1ns

interface rps_core_if;
    logic [10:0] ptr;
    logic        step_en;
    logic        word_mode;
    logic        access;
    logic [10:0] ptr_next;
    logic        swap;
    logic        dir_mode;
    logic [7:0]  even_byte;
    logic [7:0]  odd_byte;
    logic [15:0] lanes_wr;
    logic [15:0] lanes_rd;
    logic [7:0]  wr_even;
    logic [7:0]  wr_odd;

    modport top (
        output ptr, step_en, word_mode, access, swap, dir_mode,
        output even_byte, odd_byte, lanes_wr,
        input  ptr_next, lanes_rd, wr_even, wr_odd
    );
    modport stepper (
        input  ptr, step_en, word_mode, access,
        output ptr_next
    );
    modport swapper (
        input  swap, dir_mode, even_byte, odd_byte, lanes_wr,
        output lanes_rd, wr_even, wr_odd
    );
endinterface : rps_core_if

// [rps_host_model.sv]
/*
  Host processor model on the register port.
  Assumes strobes are sampled on the rising clock edge, read data one cycle later.
*/
`timescale 1ns/1ns

module rps_host_model (
    input  wire logic        i_clock,
    input  wire logic [15:0] i_rdata,
    output logic      [2:0]  o_addr,
    output logic      [15:0] o_wdata,
    output logic             o_wr,
    output logic             o_rd
);
    initial begin
        o_addr  = 3'h0;
        o_wdata = 16'h0000;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end

    // Released lines show inverted values so a stale address never repeats the last one
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge i_clock);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clock);
        o_wr    <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~d;
        #1;
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
        @(posedge i_clock);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clock);
        o_rd   <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rdata;
    endtask : rd_reg
endmodule : rps_host_model

// [rps_pkg.sv]
/*
  Constants, types and shared decoding for the RAM pointer and indirect
  select register logic of a token-passing network controller.
  Assumes a 3-bit host register address and an 11-bit buffer address.
*/
// Operation
// - Direction bit high before reading buffer data, low before writing it.
// - With stepping disabled the pointer stays put after any data access.
// - Byte mode with stepping enabled: pointer advances by one per access.
// - Word mode with stepping enabled: pointer advances by two per access.
// - Upper register bits two to zero are buffer address bits ten to eight.
// - Lower register bits seven to zero are buffer address bits seven to zero.
// - In word mode the lowest pointer bit acts as byte swap, not address.
// - Swap bit has no defined reset value; never rely on it unwritten.
// - Separate strobe host: swap 0 odd byte high, even low; 1 reverses.
// - Direction strobe host: swap 0 even byte high, odd low; 1 reverses.
// - Three-bit select routes address seven to six registers; 110, 111 reserved.
// - Low two select bits are one storage shared with configuration bits.
// - Writing the configuration register clears the top select bit.
// - Configuration bits one and zero show the two low select bits.

package rps_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int PTR_W  = 11;
    localparam int ADDR_W = 3;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [2:0] OFS_CONTROL   = 3'h1;
    localparam logic [2:0] OFS_PTR_UPPER = 3'h2;
    localparam logic [2:0] OFS_PTR_LOWER = 3'h3;
    localparam logic [2:0] OFS_DATA      = 3'h4;
    localparam logic [2:0] OFS_SELECT    = 3'h5;
    localparam logic [2:0] OFS_CONFIG    = 3'h6;
    localparam logic [2:0] OFS_INDIRECT  = 3'h7;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int UPPER_READ_DIR = 7;
    localparam int UPPER_STEP_EN  = 6;
    localparam int UPPER_RSVD     = 3;
    localparam int CONTROL_WORD   = 0;
    localparam int CONTROL_MODE   = 1;

    // ************************************************************
    // Reset values and pointer steps
    // ************************************************************
    localparam logic [7:0]  RST_UPPER   = 8'h00;
    localparam logic [7:0]  RST_LOWER   = 8'h00;
    localparam logic [7:0]  RST_CONFIG  = 8'h00;
    localparam logic        RST_WORD    = 1'h0;
    localparam logic [2:0]  RST_SELECT  = 3'h0;
    localparam logic [10:0] STEP_NONE   = 11'h000;
    localparam logic [10:0] STEP_BYTE   = 11'h001;
    localparam logic [10:0] STEP_WORD   = 11'h002;

    // ************************************************************
    // Indirect register selection
    // ************************************************************
    typedef enum logic [2:0] {
        SEL_TENTATIVE = 3'h0,
        SEL_NODE      = 3'h1,
        SEL_SETUP_ONE = 3'h2,
        SEL_NEXT      = 3'h3,
        SEL_SETUP_TWO = 3'h4,
        SEL_BUS_CTRL  = 3'h5,
        SEL_RSVD_A    = 3'h6,
        SEL_RSVD_B    = 3'h7
    } rps_sel_t;

    function automatic logic rps_sel_reserved(input rps_sel_t sel);
        case (sel)
            SEL_RSVD_A: rps_sel_reserved = 1'b1;
            SEL_RSVD_B: rps_sel_reserved = 1'b1;
            default:    rps_sel_reserved = 1'b0;
        endcase
    endfunction : rps_sel_reserved

endpackage : rps_pkg

// [rps_properties.sv]
/*
  Concurrent checks on the ports of rps_top.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns

module rps_properties (
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire logic [2:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic [2:0]  o_indirect_select,
    input wire logic        o_indirect_reserved,
    input wire logic        o_indirect_wr,
    input wire logic        o_indirect_rd,
    input wire logic [7:0]  o_indirect_wdata,
    input wire logic [10:0] o_pointer,
    input wire logic        o_word_mode
);
    logic step_q;
    wire  up_wr = i_wr && i_addr == rps_pkg::OFS_PTR_UPPER;

    // Stepping enable is not visible at the ports, so track it from host writes
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            step_q <= 1'b0;
        end else if (up_wr) begin
            step_q <= i_wdata[6];
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    sequence s_data_acc;
        (i_wr || i_rd) && i_addr == rps_pkg::OFS_DATA;
    endsequence

    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data outside answer cycle");
    step_none_a: assert property (s_data_acc ##0 !step_q |=> $stable(o_pointer))
        else $error("pointer moved with stepping off");
    step_byte_a: assert property (s_data_acc ##0 (step_q && !o_word_mode)
        |=> o_pointer - $past(o_pointer) == 11'h001) else $error("byte step wrong");
    step_word_a: assert property (s_data_acc ##0 (step_q && o_word_mode)
        |=> o_pointer - $past(o_pointer) == 11'h002) else $error("word step wrong");
    upper_bits_a: assert property (up_wr |=> o_pointer[10:8] == $past(i_wdata[2:0]))
        else $error("upper address bits wrong");
    lower_bits_a: assert property (i_wr && i_addr == rps_pkg::OFS_PTR_LOWER
        |=> o_pointer[7:0] == $past(i_wdata[7:0])) else $error("lower address bits wrong");
    select_set_a: assert property (i_wr && i_addr == rps_pkg::OFS_SELECT
        |=> o_indirect_select == $past(i_wdata[2:0])) else $error("select not loaded");
    config_clear_a: assert property (i_wr && i_addr == rps_pkg::OFS_CONFIG
        |=> o_indirect_select == {1'b0, $past(i_wdata[1:0])}) else $error("config select");
    reserved_flag_a: assert property (
        o_indirect_reserved == (o_indirect_select[2:1] == 2'b11))
        else $error("reserved flag wrong");
    window_read_a: assert property (i_rd && i_addr == rps_pkg::OFS_INDIRECT
        |=> o_indirect_rd == !$past(o_indirect_reserved)) else $error("window read pulse");
    window_write_a: assert property (i_wr && i_addr == rps_pkg::OFS_INDIRECT
        && !o_indirect_reserved |=> o_indirect_wr && o_indirect_wdata == $past(i_wdata[7:0]))
        else $error("window write pulse");
endmodule : rps_properties

// [rps_stepper.sv]
/*
  Next value of the buffer pointer after a data register access.
  Assumes the caller loads ptr_next only on a data access.
*/
`timescale 1ns/1ns

module rps_stepper (
    // Core bundle
    rps_core_if.stepper core
);
    logic [10:0] step;

    assign step = (!core.access || !core.step_en) ? rps_pkg::STEP_NONE :
                  core.word_mode ? rps_pkg::STEP_WORD :
                  rps_pkg::STEP_BYTE;

    // Eleven-bit sum wraps by itself; a word step leaves the swap bit alone
    assign core.ptr_next = core.ptr + step;
endmodule : rps_stepper

// [rps_swapper.sv]
/*
  Maps even and odd buffer bytes onto the upper and lower data lanes.
  Assumes the host interface style is already synchronised and stable.
*/
`timescale 1ns/1ns

module rps_swapper (
    // Core bundle
    rps_core_if.swapper core
);
    logic upper_is_odd;

    // Direction strobe hosts see the opposite default order
    assign upper_is_odd = core.dir_mode ? core.swap : !core.swap;

    assign core.lanes_rd = upper_is_odd ? {core.odd_byte, core.even_byte}
                                        : {core.even_byte, core.odd_byte};
    assign core.wr_odd   = upper_is_odd ? core.lanes_wr[15:8] : core.lanes_wr[7:0];
    assign core.wr_even  = upper_is_odd ? core.lanes_wr[7:0]  : core.lanes_wr[15:8];
endmodule : rps_swapper

// [rps_top.sv]
/*
  Host register logic for the buffer RAM pointer, the data window onto the
  buffer, the byte swap of word accesses and the indirect register select.
  Assumes a host port with one-cycle strobes, read data one cycle later,
  and indirect register contents held by logic outside this block.
*/
`timescale 1ns/1ns

module rps_top #(
    parameter int RAM_DEPTH = 2048
) (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // Register port
    input  wire logic [2:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    // Host interface style pin, high for direction plus data strobe hosts
    input  wire logic        i_host_dir_strobe,
    // Indirect register access at address seven
    input  wire logic [7:0]  i_indirect_rdata,
    output logic      [2:0]  o_indirect_select,
    output logic             o_indirect_reserved,
    output logic             o_indirect_wr,
    output logic             o_indirect_rd,
    output logic      [7:0]  o_indirect_wdata,
    // Status
    output logic      [10:0] o_pointer,
    output logic             o_word_mode
);

    // ************************************************************
    // Storage
    // ************************************************************
    // No reset: buffer contents are undefined until written
    logic [7:0]  ram_q [RAM_DEPTH];

    // Pointer register fields
    logic        read_dir_q;
    logic        read_dir_d;
    logic        step_en_q;
    logic        step_en_d;
    logic        upper_rsvd_q;
    logic        upper_rsvd_d;
    logic [2:0]  upper_bits_q;
    logic [2:0]  upper_bits_d;
    logic [7:0]  lower_bits_q;
    logic [7:0]  lower_bits_d;

    // Select, configuration and control
    logic        select_top_q;
    logic        select_top_d;
    logic [1:0]  select_low_q;
    logic [1:0]  select_low_d;
    logic [5:0]  config_hi_q;
    logic [5:0]  config_hi_d;
    logic        word_access_enable_q;
    logic        word_access_enable_d;

    // Host style synchroniser
    logic        mode_s1_q;
    logic        mode_s2_q;
    logic        mode_s3_q;
    logic        host_mode_q;
    logic        host_mode_d;
    logic [15:0] o_rdata_d;

    // Output next values
    rps_pkg::rps_sel_t select_next;
    logic        select_next_rsvd;
    logic        indirect_wr_d;
    logic        indirect_rd_d;
    logic [7:0]  indirect_wdata_d;
    logic [10:0] pointer_d;

    // ************************************************************
    // Address decode
    // ************************************************************
    wire         wr_control  = i_wr && (i_addr == rps_pkg::OFS_CONTROL);
    wire         wr_upper    = i_wr && (i_addr == rps_pkg::OFS_PTR_UPPER);
    wire         wr_lower    = i_wr && (i_addr == rps_pkg::OFS_PTR_LOWER);
    wire         wr_data     = i_wr && (i_addr == rps_pkg::OFS_DATA);
    wire         rd_data     = i_rd && (i_addr == rps_pkg::OFS_DATA);
    wire         wr_select   = i_wr && (i_addr == rps_pkg::OFS_SELECT);
    wire         wr_config   = i_wr && (i_addr == rps_pkg::OFS_CONFIG);
    wire         wr_indirect = i_wr && (i_addr == rps_pkg::OFS_INDIRECT);
    wire         rd_indirect = i_rd && (i_addr == rps_pkg::OFS_INDIRECT);

    // With stepping enabled any data access steps the pointer, whatever the direction
    wire         data_access = wr_data || rd_data;

    // ************************************************************
    // Pointer views
    // ************************************************************
    wire  [10:0] pointer     = {upper_bits_q, lower_bits_q};
    // In word mode bit zero carries the swap choice, so the pair is aligned
    wire  [10:0] even_addr   = {pointer[10:1], 1'b0};
    wire  [10:0] odd_addr    = {pointer[10:1], 1'b1};
    wire         swap_bit    = lower_bits_q[0];

    // ************************************************************
    // Indirect select
    // ************************************************************
    rps_pkg::rps_sel_t select;
    assign select = rps_pkg::rps_sel_t'({select_top_q, select_low_q});
    wire         select_rsvd = rps_pkg::rps_sel_reserved(select);

    // ************************************************************
    // Core helpers
    // ************************************************************
    rps_core_if core ();

    assign core.ptr       = pointer;
    assign core.step_en   = step_en_q;
    assign core.word_mode = word_access_enable_q;
    assign core.access    = data_access;
    assign core.swap      = swap_bit;
    assign core.dir_mode  = host_mode_q;
    assign core.even_byte = ram_q[even_addr];
    assign core.odd_byte  = ram_q[odd_addr];
    assign core.lanes_wr  = i_wdata;

    rps_stepper u_stepper (
        .core (core)
    );

    rps_swapper u_swapper (
        .core (core)
    );

    // ************************************************************
    // Register read selection
    // ************************************************************
    // The buffer is read asynchronously at the pointer, so the addressed
    // byte is always ready; a slow RAM would need a prefetch stage instead
    wire  [15:0] data_view   = word_access_enable_q ? core.lanes_rd
                                                    : {8'h00, ram_q[pointer]};

    wire  [7:0]  upper_view  = {read_dir_q, step_en_q, 2'h0, upper_rsvd_q, upper_bits_q};
    wire  [7:0]  select_view = {5'h00, select_top_q, select_low_q};
    wire  [7:0]  config_view = {config_hi_q, select_low_q};
    wire  [7:0]  control_view = {6'h00, host_mode_q, word_access_enable_q};
    wire  [7:0]  indir_view  = select_rsvd ? 8'h00 : i_indirect_rdata;

    wire  [15:0] rd_mux =
        (i_addr == rps_pkg::OFS_CONTROL)   ? {8'h00, control_view} :
        (i_addr == rps_pkg::OFS_PTR_UPPER) ? {8'h00, upper_view}   :
        (i_addr == rps_pkg::OFS_PTR_LOWER) ? {8'h00, lower_bits_q} :
        (i_addr == rps_pkg::OFS_DATA)      ? data_view             :
        (i_addr == rps_pkg::OFS_SELECT)    ? {8'h00, select_view}  :
        (i_addr == rps_pkg::OFS_CONFIG)    ? {8'h00, config_view}  :
        (i_addr == rps_pkg::OFS_INDIRECT)  ? {8'h00, indir_view}   :
                                             16'h0000;

    // Data stand only in the cycle after the read strobe
    assign o_rdata_d = i_rd ? rd_mux : 16'h0000;

    // ************************************************************
    // Next state of the pointer registers
    // ************************************************************
    // Reserved bits five and four are not stored and read back as zero
    assign read_dir_d   = wr_upper ? i_wdata[rps_pkg::UPPER_READ_DIR] : read_dir_q;
    assign step_en_d    = wr_upper ? i_wdata[rps_pkg::UPPER_STEP_EN]  : step_en_q;
    assign upper_rsvd_d = wr_upper ? i_wdata[rps_pkg::UPPER_RSVD]     : upper_rsvd_q;
    // Only address bits follow a step, so control bits never see a carry
    assign upper_bits_d = wr_upper    ? i_wdata[2:0]           :
                          data_access ? core.ptr_next[10:8]    :
                                        upper_bits_q;
    assign lower_bits_d = wr_lower    ? i_wdata[7:0]           :
                          data_access ? core.ptr_next[7:0]     :
                                        lower_bits_q;

    // ************************************************************
    // Next state of select, configuration and control
    // ************************************************************
    // The two low select bits have one home, written from either address
    assign select_low_d = wr_select ? i_wdata[1:0] :
                          wr_config ? i_wdata[1:0] :
                                      select_low_q;
    // Upper select bits seven to three are dropped on write
    assign select_top_d = wr_select ? i_wdata[2]   :
                          wr_config ? 1'b0         :
                                      select_top_q;
    assign config_hi_d  = wr_config ? i_wdata[7:2] : config_hi_q;
    // Setting word mode before the swap bit leaves lane order unknown
    assign word_access_enable_d = wr_control ? i_wdata[rps_pkg::CONTROL_WORD]
                                             : word_access_enable_q;

    // ************************************************************
    // Host style input
    // ************************************************************
    // The style pin is external, so a change counts once two stages agree
    // Three stages keep a slowly settling strap from flipping lane order
    assign host_mode_d = (mode_s2_q == mode_s3_q) ? mode_s3_q : host_mode_q;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            mode_s1_q   <= 1'b0;
            mode_s2_q   <= 1'b0;
            mode_s3_q   <= 1'b0;
            host_mode_q <= 1'b0;
        end else begin
            mode_s1_q   <= i_host_dir_strobe;
            mode_s2_q   <= mode_s1_q;
            mode_s3_q   <= mode_s2_q;
            host_mode_q <= host_mode_d;
        end
    end

    // ************************************************************
    // Pointer and control registers
    // ************************************************************
    // The swap bit is cleared here only to keep simulation free of unknowns;
    // software must still treat it as undefined until written
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            read_dir_q   <= rps_pkg::RST_UPPER[rps_pkg::UPPER_READ_DIR];
            step_en_q    <= rps_pkg::RST_UPPER[rps_pkg::UPPER_STEP_EN];
            upper_rsvd_q <= rps_pkg::RST_UPPER[rps_pkg::UPPER_RSVD];
            upper_bits_q <= rps_pkg::RST_UPPER[2:0];
            lower_bits_q <= rps_pkg::RST_LOWER;
        end else begin
            read_dir_q   <= read_dir_d;
            step_en_q    <= step_en_d;
            upper_rsvd_q <= upper_rsvd_d;
            upper_bits_q <= upper_bits_d;
            lower_bits_q <= lower_bits_d;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            select_top_q         <= rps_pkg::RST_SELECT[2];
            select_low_q         <= rps_pkg::RST_SELECT[1:0];
            config_hi_q          <= rps_pkg::RST_CONFIG[7:2];
            word_access_enable_q <= rps_pkg::RST_WORD;
        end else begin
            select_top_q         <= select_top_d;
            select_low_q         <= select_low_d;
            config_hi_q          <= config_hi_d;
            word_access_enable_q <= word_access_enable_d;
        end
    end

    // ************************************************************
    // Buffer RAM
    // ************************************************************
    // A data write while the read direction is set is ignored
    wire         ram_we = wr_data && !read_dir_q;
    // A word write fills the aligned pair; the swap bit only picks lanes
    wire         ram_we_word = ram_we && word_access_enable_q;
    wire         ram_we_byte = ram_we && !word_access_enable_q;

    always_ff @(posedge i_clock) begin
        if (ram_we_word) begin
            ram_q[even_addr] <= core.wr_even;
            ram_q[odd_addr]  <= core.wr_odd;
        end else if (ram_we_byte) begin
            ram_q[pointer]   <= i_wdata[7:0];
        end
    end

    // ************************************************************
    // Output next values
    // ************************************************************
    // Flag and select settle on the same edge as the select register
    assign select_next      = rps_pkg::rps_sel_t'({select_top_d, select_low_d});
    assign select_next_rsvd = rps_pkg::rps_sel_reserved(select_next);
    // Reserved codes route nowhere, so their accesses go unreported
    assign indirect_wr_d    = wr_indirect && !select_rsvd;
    assign indirect_rd_d    = rd_indirect && !select_rsvd;
    assign indirect_wdata_d = wr_indirect ? i_wdata[7:0] : 8'h00;
    assign pointer_d        = {upper_bits_d, lower_bits_d};

    // ************************************************************
    // Outputs
    // ************************************************************
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_rdata             <= 16'h0000;
            o_indirect_select   <= rps_pkg::RST_SELECT;
            o_indirect_reserved <= 1'b0;
            o_indirect_wr       <= 1'b0;
            o_indirect_rd       <= 1'b0;
            o_indirect_wdata    <= 8'h00;
            o_pointer           <= 11'h000;
            o_word_mode         <= rps_pkg::RST_WORD;
        end else begin
            o_rdata             <= o_rdata_d;
            o_indirect_select   <= select_next;
            o_indirect_reserved <= select_next_rsvd;
            o_indirect_wr       <= indirect_wr_d;
            o_indirect_rd       <= indirect_rd_d;
            o_indirect_wdata    <= indirect_wdata_d;
            o_pointer           <= pointer_d;
            o_word_mode         <= word_access_enable_d;
        end
    end

endmodule : rps_top

// [test_ram_pointer_and_subaddress.sv]
/*
  Self-checking bench for rps_top, driven through the host model.
  Assumes a 100 ns clock and the register offsets of rps_pkg.
*/
`timescale 1ns/1ns

module test_ram_pointer_and_subaddress;
    localparam logic [2:0] AU = rps_pkg::OFS_PTR_UPPER;
    localparam logic [2:0] AL = rps_pkg::OFS_PTR_LOWER;
    localparam logic [2:0] AD = rps_pkg::OFS_DATA;
    localparam logic [2:0] AS = rps_pkg::OFS_SELECT;
    localparam logic [2:0] AC = rps_pkg::OFS_CONFIG;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wr, rd, rsvd, iwr, ird, wmode;
    logic        dstb = 1'b0;
    logic [2:0]  addr, sel;
    logic [7:0]  ind = 8'h5A;
    logic [7:0]  iwd;
    logic [10:0] ptr;
    logic [15:0] wd, rdat, v;
    int          n_mismatch = 0;
    int          num_checks = 0;

    initial forever #50 clk = ~clk;

    rps_host_model rps_host_model_i (.i_clock(clk), .i_rdata(rdat), .o_addr(addr),
        .o_wdata(wd), .o_wr(wr), .o_rd(rd));
    rps_top rps_top_i (.i_clock(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdat), .i_host_dir_strobe(dstb), .i_indirect_rdata(ind),
        .o_indirect_select(sel), .o_indirect_reserved(rsvd), .o_indirect_wr(iwr),
        .o_indirect_rd(ird), .o_indirect_wdata(iwd), .o_pointer(ptr), .o_word_mode(wmode));

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic w(input logic [2:0] a, input logic [15:0] d);
        rps_host_model_i.wr_reg(a, d);
    endtask : w

    task automatic r(input string what, input logic [2:0] a, input logic [15:0] e);
        rps_host_model_i.rd_reg(a, v);
        chk(what, e, v);
    endtask : r

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #(100 * 3000);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        r("upper reset", AU, 16'h0000);
        chk("pointer reset", 16'h0000, {6'h00, ptr[10:1]});
        r("select reset", AS, 16'h0000);
        w(AU, 16'h0041);
        w(AL, 16'h0010);
        w(AD, 16'h0055);
        w(AD, 16'h0066);
        chk("byte step", 16'h0112, {5'h00, ptr});
        w(AU, 16'h00C1);
        w(AL, 16'h0010);
        w(AD, 16'h00EE);
        r("read dir write", AD, 16'h0066);
        w(AU, 16'h0081);
        w(AL, 16'h0010);
        r("no step a", AD, 16'h0055);
        r("no step b", AD, 16'h0055);
        w(AU, 16'h0047);
        w(AL, 16'h00FF);
        w(AD, 16'h0001);
        chk("wrap", 16'h0000, {5'h00, ptr});
        r("wrap upper", AU, 16'h0040);
        // Swap is written before word mode is turned on
        w(AL, 16'h0000);
        w(rps_pkg::OFS_CONTROL, 16'h0001);
        chk("word mode", 16'h0001, {15'h0000, wmode});
        w(AU, 16'h0042);
        w(AL, 16'h0000);
        w(AD, 16'hBBAA);
        chk("word step", 16'h0202, {5'h00, ptr});
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) dstb <= i[1];
            repeat (5) @(posedge clk);
            w(AU, 16'h0082);
            w(AL, {15'h0000, i[0]});
            r("lanes", AD, ((i[1] ? i[0] : !i[0]) ? 16'hBBAA : 16'hAABB));
            r("host style", rps_pkg::OFS_CONTROL, {14'h0000, i[1], 1'b1});
        end
        w(rps_pkg::OFS_CONTROL, 16'h0000);
        chk("byte mode", 16'h0000, {15'h0000, wmode});
        for (int s = 0; s < 8; s++) begin
            w(AS, 16'(s));
            chk("select", 16'(s), {13'h0000, sel});
            chk("reserved", {15'h0000, s > 5}, {15'h0000, rsvd});
            r("window", rps_pkg::OFS_INDIRECT, (s > 5) ? 16'h0000 : 16'h005A);
            chk("window rd", {15'h0000, s < 6}, {15'h0000, ird});
            w(rps_pkg::OFS_INDIRECT, 16'h0033);
            chk("window wr", {7'h00, s < 6, 8'h33}, {7'h00, iwr, iwd});
        end
        w(AS, 16'h0005);
        w(AC, 16'h0003);
        chk("config clears top", 16'h0003, {13'h0000, sel});
        r("config view", AC, 16'h0003);
        w(AS, 16'h0002);
        r("shared bits", AC, 16'h0002);
        w(3'h0, 16'h00FF);
        r("unmapped", 3'h0, 16'h0000);
        end_of_test();
    end
endmodule : test_ram_pointer_and_subaddress

bind rps_top rps_properties rps_properties_i (.i_clock(i_clock), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_indirect_select(o_indirect_select), .o_indirect_reserved(o_indirect_reserved),
    .o_indirect_wr(o_indirect_wr), .o_indirect_rd(o_indirect_rd),
    .o_indirect_wdata(o_indirect_wdata), .o_pointer(o_pointer), .o_word_mode(o_word_mode));
